// [spi_slave_ram_fifo_tb_top.sv]
// Purpose: directed bench for the spi slave queue block
// Assumes: 40 MHz mclk, inputs driven on falling edges
// Notes: overflow clear is left tied low
`timescale 1ns/1ps
module spi_slave_ram_fifo_tb_top;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic sck, sel_b, mosi, miso, miso_oe, src;
    sss_pkg::sss_cfg_s cfg_in = '0;
    logic cfg_apply_in = 1'b0;
    logic tx_wr_valid_in = 1'b0;
    logic [7:0] tx_wr_data_in = 8'h00;
    logic rx_rd_ready_in = 1'b0;
    logic tx_wr_ready_out, rx_rd_valid_out;
    logic [7:0] rx_rd_data_out, tx_fill_out, rx_fill_out, status_out;
    sss_pkg::sss_irq_s irq_out;
    int err_count = 0;
    int compares = 0;
    logic [7:0] mo [3] = '{8'hC3, 8'h5A, 8'h0F};

    initial forever #12.5 mclk_in = ~mclk_in;

    sss_top sss_top_i (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .spi_sck_in(sck), .spi_sel_b_in(sel_b),
        .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .cfg_in(cfg_in),
        .cfg_apply_in(cfg_apply_in), .ovf_clr_in(1'b0), .tx_wr_valid_in(tx_wr_valid_in),
        .tx_wr_data_in(tx_wr_data_in), .tx_wr_ready_out(tx_wr_ready_out),
        .rx_rd_valid_out(rx_rd_valid_out), .rx_rd_data_out(rx_rd_data_out),
        .rx_rd_ready_in(rx_rd_ready_in), .tx_fill_out(tx_fill_out), .rx_fill_out(rx_fill_out),
        .status_out(status_out), .irq_out(irq_out), .slave_port_interrupt_source_out(src)
    );
    sss_mst sss_mst_i (.sck_out(sck), .sel_b_out(sel_b), .mosi_out(mosi), .miso_in(miso),
        .miso_oe_in(miso_oe));

    task automatic finish_test();
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // ready is settled at the falling edge and holds through the taking edge
    task automatic tx_wr(input logic [7:0] d);
        int n = 0;
        @(negedge mclk_in);
        tx_wr_valid_in = 1'b1;
        tx_wr_data_in = d;
        while (!tx_wr_ready_out && n < 50)
        begin
            n++;
            @(negedge mclk_in);
        end
        chk({7'h00, tx_wr_ready_out}, 8'h01);
        @(negedge mclk_in);
        tx_wr_valid_in = 1'b0;
    endtask

    task automatic rx_rd(input logic [7:0] exp);
        @(negedge mclk_in);
        chk({7'h00, rx_rd_valid_out}, 8'h01);
        chk(rx_rd_data_out, exp);
        rx_rd_ready_in = 1'b1;
        @(negedge mclk_in);
        rx_rd_ready_in = 1'b0;
    endtask

    task automatic xf(input logic [7:0] mb, input logic [7:0] exp);
        logic [7:0] r;
        sss_mst_i.xfer(mb, r);
        chk(r, exp);
    endtask

    task automatic apply();
        cfg_apply_in = 1'b1;
        ticks(1);
        cfg_apply_in = 1'b0;
    endtask

    initial
    begin
        #100000;
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        cfg_in = '{1'b0, 1'b1, 9'h000, 8'h04, 8'h02, 9'h100, 8'h04, 8'h01, 16'h0002};
        ticks(8);
        rst_b_in = 1'b1;
        ticks(2);
        chk(tx_fill_out, 8'h00);
        chk(status_out & 8'h05, 8'h05);
        chk({5'h00, irq_out}, 8'h04);
        apply();
        xf(8'hA5, 8'h00);
        ticks(8);
        rx_rd(8'hA5);
        for (int i = 0; i < 5; i++)
            tx_wr(8'(8'h31 + i));
        ticks(2);
        chk(tx_fill_out, 8'h04);
        tx_wr_valid_in = 1'b1;
        tx_wr_data_in = 8'hEE;
        ticks(2);
        tx_wr_valid_in = 1'b0;
        chk({7'h00, tx_wr_ready_out}, 8'h00);
        chk(tx_fill_out, 8'h04);
        chk({5'h00, irq_out}, 8'h00);
        for (int i = 0; i < 3; i++)
            xf(mo[i], 8'(8'h31 + i));
        ticks(8);
        chk(tx_fill_out, 8'h01);
        chk({5'h00, irq_out}, 8'h06);
        chk({7'h00, src}, 8'h01);
        for (int i = 0; i < 3; i++)
            rx_rd(mo[i]);
        xf(8'h77, 8'h34);
        ticks(60);
        chk({5'h00, irq_out}, 8'h04);
        ticks(30);
        chk({5'h00, irq_out}, 8'h05);
        chk(status_out & 8'h40, 8'h40);
        rx_rd(8'h77);
        ticks(3);
        chk({5'h00, irq_out}, 8'h04);
        sss_mst_i.noise();
        ticks(10);
        chk(rx_fill_out, 8'h00);
        cfg_in.lsb_first = 1'b1;
        cfg_in.int_en = 1'b0;
        apply();
        tx_wr(8'h01);
        ticks(4);
        chk(status_out & 8'h80, 8'h80);
        xf(8'hC1, 8'h80);
        ticks(8);
        chk({4'h0, irq_out, src}, 8'h00);
        rx_rd(8'h83);
        finish_test();
    end
endmodule

// [sss_fifo.sv]
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes: depth is a power of two
`timescale 1ns/1ps
module sss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_q != rd_q;
    assign out_data_out = mem_q[rd_q[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// [sss_link.sv]
// Purpose: serial shifter running on the master's serial clock
// Assumes: serial clock may also toggle while select is inactive; those edges are ignored
// Notes: select high clears the bit counters asynchronously
`timescale 1ns/1ps
module sss_link (
    // reset from the system side, async to this domain
    input wire logic rst_b_in,
    // link pins
    input wire logic sck_in,
    input wire logic sel_b_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    // quasi-static inputs, held while selected
    input wire logic lsb_first_in,
    input wire logic [7:0] tx_byte_in,
    // received byte and its toggle
    output logic [7:0] rx_byte_out,
    output logic rx_tgl_out
);
    logic [2:0] in_cnt_q;
    logic [2:0] out_idx_q;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] rx_byte_q;
    logic rx_tgl_q;

    assign shift_d = lsb_first_in ? {mosi_in, shift_q[7:1]} : {shift_q[6:0], mosi_in};

    // sample on rising edge only while selected
    always_ff @(posedge sck_in or posedge sel_b_in)
    begin
        if (sel_b_in)
        begin
            in_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end
        else
        begin
            shift_q <= shift_d;
            in_cnt_q <= in_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge sck_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_byte_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end
        else if (!sel_b_in && in_cnt_q == 3'h7)
        begin
            rx_byte_q <= shift_d;
            rx_tgl_q <= ~rx_tgl_q;
        end
    end

    // change outgoing bit on falling edge
    always_ff @(negedge sck_in or posedge sel_b_in)
    begin
        if (sel_b_in)
        begin
            out_idx_q <= 3'h0;
        end
        else
        begin
            out_idx_q <= out_idx_q + 3'h1;
        end
    end

    assign miso_out = tx_byte_in[lsb_first_in ? out_idx_q : 3'h7 - out_idx_q];
    assign miso_oe_out = ~sel_b_in;
    assign rx_byte_out = rx_byte_q;
    assign rx_tgl_out = rx_tgl_q;
endmodule

// [sss_mst.sv]
// Purpose: behavioural remote spi master, mode 0, msb first
// Assumes: sck half period 6 ns, toggled inside a frame except by noise, which clocks with select high
// Notes: mosi flips when deselected so a stale bit never looks valid
`timescale 1ns/1ps
module sss_mst (
    // link pins
    output logic sck_out,
    output logic sel_b_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    initial
    begin
        sck_out = 1'b0;
        sel_b_out = 1'b1;
        mosi_out = 1'b0;
    end

    // one byte per selection
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        sel_b_out = 1'b0;
        mosi_out = tx[7];
        for (int i = 7; i >= 0; i--)
        begin
            #6 sck_out = 1'b1;
            rx[i] = miso_oe_in ? miso_in : 1'bx;
            #6 sck_out = 1'b0;
            if (i > 0)
                mosi_out = tx[i-1];
        end
        #6 sel_b_out = 1'b1;
        mosi_out = ~mosi_out;
        #150;
    endtask

    // clock edges with select high
    task automatic noise();
        repeat (8)
        begin
            #6 sck_out = 1'b1;
            #6 sck_out = 1'b0;
            mosi_out = ~mosi_out;
        end
    endtask
endmodule

// [sss_pkg.sv]
// Purpose: shared constants and carriers for the spi slave port with ram queues
// Assumes: mclk at 40 MHz
// Notes: every number used by more than one file lives here
package sss_pkg;
    localparam int CLK_MHZ = 40;
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int MIN_SEL_GAP_NS = 125;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int SPI_MODE = 0;
    localparam int BYTE_W = 8;
    localparam int RAM_AW = 9;
    localparam int RAM_WORDS = 512;
    localparam int QUEUE_MAX = 255;
    localparam int XFER_FIFO_DEPTH = 16;
    localparam int TIMEOUT_W = 16;
    localparam logic [7:0] TX_IDLE_BYTE = 8'h00;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    // status bit positions
    localparam int ST_RX_EMPTY = 0;
    localparam int ST_RX_FULL = 1;
    localparam int ST_TX_EMPTY = 2;
    localparam int ST_TX_FULL = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_OVERFLOW = 5;
    localparam int ST_TIMEOUT = 6;
    localparam int ST_TX_LOADED = 7;

    typedef struct packed {
        logic lsb_first;
        logic int_en;
        logic [RAM_AW-1:0] tx_base;
        logic [7:0] tx_size;
        logic [7:0] tx_thr;
        logic [RAM_AW-1:0] rx_base;
        logic [7:0] rx_size;
        logic [7:0] rx_thr;
        logic [TIMEOUT_W-1:0] timeout_us;
    } sss_cfg_s;

    typedef struct packed {
        logic tx_thresh;
        logic rx_thresh;
        logic rx_timeout;
    } sss_irq_s;
endpackage

// [sss_top.sv]
// Purpose: spi slave port with transmit and receive queues held in local ram
// Assumes: mclk 40 MHz; serial clock is a separate domain owned by the remote master
// Notes:
`timescale 1ns/1ps
module sss_top #(
    parameter int FIFO_DEPTH = sss_pkg::XFER_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // link pins
    input wire logic spi_sck_in,
    input wire logic spi_sel_b_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // configuration
    input wire sss_pkg::sss_cfg_s cfg_in,
    input wire logic cfg_apply_in,
    input wire logic ovf_clr_in,
    // transmit queue write
    input wire logic tx_wr_valid_in,
    input wire logic [7:0] tx_wr_data_in,
    output logic tx_wr_ready_out,
    // receive queue read
    output logic rx_rd_valid_out,
    output logic [7:0] rx_rd_data_out,
    input wire logic rx_rd_ready_in,
    // monitoring
    output logic [7:0] tx_fill_out,
    output logic [7:0] rx_fill_out,
    output logic [7:0] status_out,
    output sss_pkg::sss_irq_s irq_out,
    output logic slave_port_interrupt_source_out
);
    localparam int AW = sss_pkg::RAM_AW;
    localparam int PRE_W = $clog2(sss_pkg::CYC_PER_US);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(sss_pkg::CYC_PER_US - 1);

    logic [7:0] ram_q [0:sss_pkg::RAM_WORDS-1];
    logic [7:0] tx_wr_q, tx_rd_q, tx_cnt_q;
    logic [7:0] rx_wr_q, rx_rd_q, rx_cnt_q;
    logic [7:0] tx_hold_q;
    logic tx_loaded_q;
    logic sel_s1_q, sel_s2_q, sel_prev_q;
    logic tgl_s1_q, tgl_s2_q, tgl_prev_q;
    logic [7:0] link_rx_byte;
    logic link_rx_tgl;
    logic selected, frame_start, frame_end, byte_evt;
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic ovf_q;
    logic to_arm_q, to_flag_q;
    logic [PRE_W-1:0] pre_q;
    logic [sss_pkg::TIMEOUT_W-1:0] us_q;
    sss_pkg::sss_irq_s irq_q;

    function automatic logic [7:0] wrap_inc(input logic [7:0] off, input logic [7:0] size);
        wrap_inc = (off + 8'h01 >= size) ? 8'h00 : off + 8'h01;
    endfunction

    function automatic logic [AW-1:0] ram_addr(input logic [AW-1:0] base, input logic [7:0] off);
        ram_addr = base + AW'(off);
    endfunction

    sss_link u_link (
        .rst_b_in(rst_b_in),
        .sck_in(spi_sck_in),
        .sel_b_in(spi_sel_b_in),
        .mosi_in(spi_mosi_in),
        .miso_out(spi_miso_out),
        .miso_oe_out(spi_miso_oe_out),
        .lsb_first_in(cfg_in.lsb_first),
        .tx_byte_in(tx_hold_q),
        .rx_byte_out(link_rx_byte),
        .rx_tgl_out(link_rx_tgl)
    );

    // crossings from the serial clock domain
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
            sel_prev_q <= 1'b1;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_prev_q <= 1'b0;
        end
        else
        begin
            sel_s1_q <= spi_sel_b_in;
            sel_s2_q <= sel_s1_q;
            sel_prev_q <= sel_s2_q;
            tgl_s1_q <= link_rx_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_prev_q <= tgl_s2_q;
        end
    end

    assign selected = !sel_s2_q;
    assign frame_start = sel_prev_q && !sel_s2_q;
    assign frame_end = !sel_prev_q && sel_s2_q;
    assign byte_evt = tgl_s2_q != tgl_prev_q;

    // received bytes pass a small fifo before the ram queue
    sss_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(mclk_in),
        .rst_b_in(rst_b_in && !cfg_apply_in),
        .in_valid_in(byte_evt),
        .in_data_in(link_rx_byte),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(rx_push)
    );

    assign tx_push = tx_wr_valid_in && tx_wr_ready_out;
    // no pop in the frame_end cycle, or the popped byte would be lost
    assign tx_pop = !selected && !frame_end && !tx_loaded_q && tx_cnt_q != sss_pkg::CNT_ZERO;
    assign rx_push = fifo_out_valid && rx_cnt_q < cfg_in.rx_size;
    assign rx_pop = rx_rd_ready_in && rx_rd_valid_out;
    assign tx_wr_ready_out = tx_cnt_q < cfg_in.tx_size;

    // shared ram holding both queues
    always_ff @(posedge mclk_in)
    begin
        if (tx_push)
        begin
            ram_q[ram_addr(cfg_in.tx_base, tx_wr_q)] <= tx_wr_data_in;
        end
        if (rx_push)
        begin
            ram_q[ram_addr(cfg_in.rx_base, rx_wr_q)] <= fifo_out_data;
        end
    end

    // transmit queue pointers
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || cfg_apply_in)
        begin
            tx_wr_q <= 8'h00;
            tx_rd_q <= 8'h00;
            tx_cnt_q <= 8'h00;
        end
        else
        begin
            if (tx_push)
            begin
                tx_wr_q <= wrap_inc(tx_wr_q, cfg_in.tx_size);
            end
            if (tx_pop)
            begin
                tx_rd_q <= wrap_inc(tx_rd_q, cfg_in.tx_size);
            end
            tx_cnt_q <= tx_cnt_q + 8'(tx_push) - 8'(tx_pop);
        end
    end

    // receive queue pointers
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || cfg_apply_in)
        begin
            rx_wr_q <= 8'h00;
            rx_rd_q <= 8'h00;
            rx_cnt_q <= 8'h00;
        end
        else
        begin
            if (rx_push)
            begin
                rx_wr_q <= wrap_inc(rx_wr_q, cfg_in.rx_size);
            end
            if (rx_pop)
            begin
                rx_rd_q <= wrap_inc(rx_rd_q, cfg_in.rx_size);
            end
            rx_cnt_q <= rx_cnt_q + 8'(rx_push) - 8'(rx_pop);
        end
    end

    assign rx_rd_valid_out = rx_cnt_q != sss_pkg::CNT_ZERO;
    assign rx_rd_data_out = ram_q[ram_addr(cfg_in.rx_base, rx_rd_q)];

    // transmit byte handed to the link, only changed while deselected
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || cfg_apply_in)
        begin
            tx_hold_q <= sss_pkg::TX_IDLE_BYTE;
            tx_loaded_q <= 1'b0;
        end
        else if (frame_end)
        begin
            tx_hold_q <= sss_pkg::TX_IDLE_BYTE;
            tx_loaded_q <= 1'b0;
        end
        else if (tx_pop)
        begin
            tx_hold_q <= ram_q[ram_addr(cfg_in.tx_base, tx_rd_q)];
            tx_loaded_q <= 1'b1;
        end
    end

    // overflow when the link delivers into a full fifo; set wins over clear
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            ovf_q <= 1'b0;
        end
        else if (byte_evt && !fifo_in_ready)
        begin
            ovf_q <= 1'b1;
        end
        else if (ovf_clr_in)
        begin
            ovf_q <= 1'b0;
        end
    end

    // microsecond prescaler
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || !to_arm_q || rx_cnt_q == sss_pkg::CNT_ZERO || pre_q == PRE_LAST)
        begin
            pre_q <= '0;
        end
        else
        begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // receive timeout armed by the end of a transfer
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || frame_start)
        begin
            to_arm_q <= 1'b0;
            to_flag_q <= 1'b0;
            us_q <= '0;
        end
        else if (frame_end)
        begin
            to_arm_q <= 1'b1;
            us_q <= '0;
        end
        else if (rx_cnt_q == sss_pkg::CNT_ZERO)
        begin
            // stay armed: the last byte may still be on its way into the queue
            to_flag_q <= 1'b0;
            us_q <= '0;
        end
        else if (to_arm_q && pre_q == PRE_LAST)
        begin
            if (us_q + 1'b1 >= cfg_in.timeout_us)
            begin
                to_flag_q <= 1'b1;
                to_arm_q <= 1'b0;
            end
            else
            begin
                us_q <= us_q + 1'b1;
            end
        end
    end

    // interrupt lines
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            irq_q <= '0;
            slave_port_interrupt_source_out <= 1'b0;
        end
        else
        begin
            irq_q.tx_thresh <= cfg_in.int_en && tx_cnt_q < cfg_in.tx_thr;
            irq_q.rx_thresh <= cfg_in.int_en && rx_cnt_q > cfg_in.rx_thr;
            irq_q.rx_timeout <= cfg_in.int_en && to_flag_q;
            slave_port_interrupt_source_out <= cfg_in.int_en && (tx_cnt_q < cfg_in.tx_thr
                || rx_cnt_q > cfg_in.rx_thr || to_flag_q);
        end
    end

    assign irq_out = irq_q;
    assign tx_fill_out = tx_cnt_q;
    assign rx_fill_out = rx_cnt_q;

    always_comb
    begin
        status_out = 8'h00;
        status_out[sss_pkg::ST_RX_EMPTY] = rx_cnt_q == sss_pkg::CNT_ZERO;
        status_out[sss_pkg::ST_RX_FULL] = rx_cnt_q >= cfg_in.rx_size;
        status_out[sss_pkg::ST_TX_EMPTY] = tx_cnt_q == sss_pkg::CNT_ZERO;
        status_out[sss_pkg::ST_TX_FULL] = tx_cnt_q >= cfg_in.tx_size;
        status_out[sss_pkg::ST_BUSY] = selected;
        status_out[sss_pkg::ST_OVERFLOW] = ovf_q;
        status_out[sss_pkg::ST_TIMEOUT] = to_flag_q;
        status_out[sss_pkg::ST_TX_LOADED] = tx_loaded_q;
    end
endmodule

// [sss_top_sva.sv]
// Purpose: port-level checks for the spi slave queue block
// Assumes: cfg_in only changes while the link is idle
// Notes: bound to every sss_top instance
`timescale 1ns/1ps
module sss_top_chk #(
    parameter int FIFO_DEPTH = sss_pkg::XFER_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // link and configuration
    input wire logic spi_sel_b_in,
    input wire logic spi_miso_oe_out,
    input wire sss_pkg::sss_cfg_s cfg_in,
    // queues and monitoring
    input wire logic tx_wr_ready_out,
    input wire logic rx_rd_valid_out,
    input wire logic [7:0] tx_fill_out,
    input wire logic [7:0] rx_fill_out,
    input wire logic [7:0] status_out,
    input wire sss_pkg::sss_irq_s irq_out,
    input wire logic slave_port_interrupt_source_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    chk_oe_sel: assert property (spi_miso_oe_out == !spi_sel_b_in)
        else $error("miso enable not tied to select");
    chk_tx_ready: assert property (tx_wr_ready_out == (tx_fill_out < cfg_in.tx_size))
        else $error("tx ready wrong for fill");
    chk_rx_cap: assert property (rx_fill_out <= cfg_in.rx_size)
        else $error("rx fill beyond size");
    chk_tx_thr: assert property ($past(rst_b_in) |->
        irq_out.tx_thresh == $past(cfg_in.int_en && tx_fill_out < cfg_in.tx_thr))
        else $error("tx threshold level wrong");
    chk_rx_thr: assert property ($past(rst_b_in) |->
        irq_out.rx_thresh == $past(cfg_in.int_en && rx_fill_out > cfg_in.rx_thr))
        else $error("rx threshold level wrong");
    chk_to_empty: assert property (rx_fill_out == 8'h00 [*3] |-> !irq_out.rx_timeout)
        else $error("timeout with empty rx queue");
    chk_int_off: assert property (!cfg_in.int_en [*2] |->
        irq_out == 3'h0 && !slave_port_interrupt_source_out)
        else $error("interrupt while disabled");
    chk_rx_valid: assert property (rx_rd_valid_out == (rx_fill_out != 8'h00))
        else $error("rx valid disagrees with fill");
    chk_st_empty: assert property (status_out[sss_pkg::ST_RX_EMPTY] == (rx_fill_out == 8'h00)
        && status_out[sss_pkg::ST_TX_EMPTY] == (tx_fill_out == 8'h00))
        else $error("empty status bits wrong");
    chk_rx_idle: assert property (spi_sel_b_in [*8] |=> rx_fill_out <= $past(rx_fill_out))
        else $error("rx grew while deselected");
endmodule

bind sss_top sss_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) sss_top_chk_i (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .spi_sel_b_in(spi_sel_b_in),
    .spi_miso_oe_out(spi_miso_oe_out), .cfg_in(cfg_in), .tx_wr_ready_out(tx_wr_ready_out),
    .rx_rd_valid_out(rx_rd_valid_out), .tx_fill_out(tx_fill_out), .rx_fill_out(rx_fill_out),
    .status_out(status_out), .irq_out(irq_out),
    .slave_port_interrupt_source_out(slave_port_interrupt_source_out)
);
